// ===== rtl/tew_unit.v
`timescale 1ns/1ps
`default_nettype none
`include "tew_consts.vh"
module tew_unit #(
  parameter CW = 32,
  parameter NW = 16
) (
  input  wire        clock_i,
  input  wire        reset_n_i,
  input  wire [3:0]  reg_addr_i,
  input  wire [31:0] reg_wdata_i,
  input  wire        reg_write_i,
  input  wire        reg_read_i,
  output reg  [31:0] reg_rdata_o,
  input  wire        target_reached_i,
  input  wire        peer_pin1_i,
  input  wire        peer_pin2_i,
  output wire        event_pin1_o,
  output wire        event_pin2_o
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_ON   = 4'b0010;
  localparam ST_OFF  = 4'b0100;
  localparam ST_DONE = 4'b1000;

  reg  [31:0]   ctrl_q;
  reg  [CW-1:0] width_q;
  reg  [31:0]   pat_q;
  reg  [CW-1:0] cascade_q;
  reg  [3:0]    state_q;
  reg  [3:0]    state_d;
  reg  [CW-1:0] tick_q;
  reg  [CW-1:0] tick_d;
  reg  [NW-1:0] cycles_q;
  reg  [NW-1:0] cycles_d;
  reg  [3:0]    bit_q;
  reg  [3:0]    bit_d;
  reg  [NW-1:0] passes_q;
  reg  [NW-1:0] passes_d;
  reg           level_q;
  reg           level_d;
  wire          trig_sync;
  wire          pin1_sync;
  wire          pin2_sync;
  wire          wave;
  wire [2:0]    shape;
  wire          enable;
  wire          clear;
  wire          casc;
  wire          tail;
  wire          edge_neg;
  wire          pin_sel;
  wire [15:0]   iter;
  wire [NW-1:0] count;
  wire [15:0]   pattern;
  wire          width_done;
  wire          count_done;
  wire          pat_bit;

  function idle_level;
    input [2:0] sh;
    begin
      case (sh)
        `TEW_SHAPE_POS_EDGE: idle_level = 1'b0;
        `TEW_SHAPE_POS_PULS: idle_level = 1'b0;
        `TEW_SHAPE_POS_PER:  idle_level = 1'b0;
        default:             idle_level = 1'b1;
      endcase
    end
  endfunction

  assign shape    = ctrl_q[`TEW_CTRL_SHAPE_HI:`TEW_CTRL_SHAPE_LO];
  assign enable   = ctrl_q[`TEW_CTRL_EN_BIT];
  assign clear    = ctrl_q[`TEW_CTRL_CLR_BIT];
  assign casc     = ctrl_q[`TEW_CTRL_CASC_BIT];
  assign tail     = ctrl_q[`TEW_CTRL_TAIL_BIT];
  assign edge_neg = ctrl_q[`TEW_CTRL_EDGE_BIT];
  assign pin_sel  = ctrl_q[`TEW_CTRL_PIN_BIT];
  assign iter     = ctrl_q[`TEW_CTRL_ITER_HI:`TEW_CTRL_ITER_LO];
  assign count    = pat_q[`TEW_PAT_COUNT_HI:`TEW_PAT_COUNT_LO];
  assign pattern  = pat_q[`TEW_PAT_BITS_HI:`TEW_PAT_BITS_LO];
  // Width of one clock minimum; zero treated as one
  assign width_done = (tick_q + {{(CW-1){1'b0}}, 1'b1}) >= width_q;
  assign pat_bit    = pattern[4'hF - bit_q];

  // Target-time match arrives from the time base, possibly another domain
  tew_sync #(
    .WIDTH (3)
  ) u_sync (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .async_i   ({target_reached_i, peer_pin1_i, peer_pin2_i}),
    .sync_o    ({trig_sync, pin1_sync, pin2_sync})
  );

  // Register port
  always @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ctrl_q    <= `TEW_RST_CTRL;
      width_q   <= `TEW_RST_WIDTH;
      pat_q     <= `TEW_RST_PATTERN;
      cascade_q <= `TEW_RST_CASCADE;
    end
    else
    begin
      // Soft clear is self-clearing once the sequencer has seen it
      if (clear)
        ctrl_q[`TEW_CTRL_CLR_BIT] <= 1'b0;
      if (reg_write_i)
      begin
        case (reg_addr_i)
          `TEW_ADDR_CTRL:    ctrl_q    <= reg_wdata_i & `TEW_CTRL_WMASK;
          `TEW_ADDR_WIDTH:   width_q   <= reg_wdata_i[CW-1:0];
          `TEW_ADDR_PATTERN: pat_q     <= reg_wdata_i;
          `TEW_ADDR_CASCADE: cascade_q <= reg_wdata_i[CW-1:0];
          default:           ;
        endcase
      end
    end
  end

  always @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      reg_rdata_o <= 32'h00000000;
    else if (reg_read_i)
    begin
      case (reg_addr_i)
        `TEW_ADDR_CTRL:    reg_rdata_o <= ctrl_q;
        `TEW_ADDR_WIDTH:   reg_rdata_o <= {{(32-CW){1'b0}}, width_q};
        `TEW_ADDR_PATTERN: reg_rdata_o <= pat_q;
        `TEW_ADDR_CASCADE: reg_rdata_o <= {{(32-CW){1'b0}}, cascade_q};
        `TEW_ADDR_STATUS:  reg_rdata_o <= {27'h0000000, wave, state_q};
        default:           reg_rdata_o <= 32'h00000000;
      endcase
    end
    else
      reg_rdata_o <= 32'h00000000;
  end

  assign count_done = (count != {NW{1'b0}}) &&
                      (cycles_q + {{(NW-1){1'b0}}, 1'b1} >= count);

  // Waveform sequencer
  always @*
  begin
    state_d  = state_q;
    tick_d   = tick_q;
    cycles_d = cycles_q;
    bit_d    = bit_q;
    passes_d = passes_q;
    level_d  = level_q;
    case (state_q)
      ST_IDLE:
      begin
        level_d  = idle_level(shape);
        tick_d   = {CW{1'b0}};
        cycles_d = {NW{1'b0}};
        bit_d    = 4'h0;
        passes_d = {NW{1'b0}};
        if (enable && trig_sync)
        begin
          state_d = ST_ON;
          case (shape)
            `TEW_SHAPE_NEG_EDGE: begin level_d = 1'b0; state_d = ST_DONE; end
            `TEW_SHAPE_POS_EDGE: begin level_d = 1'b1; state_d = ST_DONE; end
            `TEW_SHAPE_NEG_PULS: level_d = 1'b0;
            `TEW_SHAPE_POS_PULS: level_d = 1'b1;
            `TEW_SHAPE_NEG_PER:  level_d = 1'b0;
            `TEW_SHAPE_POS_PER:  level_d = 1'b1;
            `TEW_SHAPE_PATTERN:  level_d = pattern[4'hF];
            default:             state_d = ST_IDLE;
          endcase
        end
      end
      ST_ON:
      begin
        tick_d = tick_q + {{(CW-1){1'b0}}, 1'b1};
        if (width_done)
        begin
          tick_d = {CW{1'b0}};
          case (shape)
            `TEW_SHAPE_NEG_PULS: begin level_d = 1'b1; state_d = ST_DONE; end
            `TEW_SHAPE_POS_PULS: begin level_d = 1'b0; state_d = ST_DONE; end
            `TEW_SHAPE_NEG_PER,
            `TEW_SHAPE_POS_PER:
            begin
              level_d = ~level_q;
              state_d = ST_OFF;
            end
            `TEW_SHAPE_PATTERN:
            begin
              bit_d    = bit_q + 4'h1;
              cycles_d = cycles_q + {{(NW-1){1'b0}}, 1'b1};
              // Plain mode stops on bit total; cascade counts whole passes
              if (casc)
              begin
                if (bit_q == 4'hF)
                begin
                  passes_d = passes_q + {{(NW-1){1'b0}}, 1'b1};
                  if (tail && passes_q >= iter)
                  begin
                    state_d = ST_DONE;
                    level_d = idle_level(shape);
                  end
                  else
                    level_d = pattern[4'hF];
                end
                else
                  level_d = pattern[4'hE - bit_q];
              end
              else if (count_done)
              begin
                state_d = ST_DONE;
                level_d = idle_level(shape);
              end
              else
                level_d = pattern[4'hE - bit_q];
            end
            default: state_d = ST_IDLE;
          endcase
        end
      end
      ST_OFF:
      begin
        // Second half of a period uses the same programmed width
        tick_d = tick_q + {{(CW-1){1'b0}}, 1'b1};
        if (width_done)
        begin
          tick_d   = {CW{1'b0}};
          cycles_d = cycles_q + {{(NW-1){1'b0}}, 1'b1};
          if (count_done)
            state_d = ST_DONE;
          else
          begin
            level_d = ~level_q;
            state_d = ST_ON;
          end
        end
      end
      ST_DONE:
      begin
        // Final level holds until software clears the enable bit or sets soft clear
        if (!enable)
          state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
    if (clear)
    begin
      state_d = ST_IDLE;
      level_d = idle_level(shape);
    end
  end

  always @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_q  <= ST_IDLE;
      tick_q   <= {CW{1'b0}};
      cycles_q <= {NW{1'b0}};
      bit_q    <= 4'h0;
      passes_q <= {NW{1'b0}};
      level_q  <= 1'b1;
    end
    else
    begin
      state_q  <= state_d;
      tick_q   <= tick_d;
      cycles_q <= cycles_d;
      bit_q    <= bit_d;
      passes_q <= passes_d;
      level_q  <= level_d;
    end
  end

  tew_launch u_launch (
    .clock_i    (clock_i),
    .reset_n_i  (reset_n_i),
    .level_i    (level_q),
    .neg_edge_i (edge_neg),
    .wave_o     (wave)
  );

  // Idle-low shapes OR in cleanly; others dominate the shared pin
  assign event_pin1_o = (!pin_sel & wave) | pin1_sync;
  assign event_pin2_o = ( pin_sel & wave) | pin2_sync;
endmodule
`default_nettype wire

// ===== rtl/tew_consts.vh
`ifndef TEW_CONSTS_VH
`define TEW_CONSTS_VH
// Register addresses (4-bit index on the plain port)
`define TEW_ADDR_CTRL      4'h0
`define TEW_ADDR_WIDTH     4'h1
`define TEW_ADDR_PATTERN   4'h2
`define TEW_ADDR_CASCADE   4'h3
`define TEW_ADDR_STATUS    4'h4
// Control register fields
`define TEW_CTRL_EN_BIT    31
`define TEW_CTRL_CLR_BIT   30
`define TEW_CTRL_CASC_BIT  29
`define TEW_CTRL_TAIL_BIT  28
`define TEW_CTRL_EDGE_BIT  23
`define TEW_CTRL_SHAPE_HI  22
`define TEW_CTRL_SHAPE_LO  20
`define TEW_CTRL_PIN_BIT   16
`define TEW_CTRL_ITER_HI   15
`define TEW_CTRL_ITER_LO   0
`define TEW_CTRL_WMASK     32'hF0F1FFFF
// Pattern register fields
`define TEW_PAT_COUNT_HI   31
`define TEW_PAT_COUNT_LO   16
`define TEW_PAT_BITS_HI    15
`define TEW_PAT_BITS_LO    0
// Shape codes
`define TEW_SHAPE_NEG_EDGE 3'h0
`define TEW_SHAPE_POS_EDGE 3'h1
`define TEW_SHAPE_NEG_PULS 3'h2
`define TEW_SHAPE_POS_PULS 3'h3
`define TEW_SHAPE_NEG_PER  3'h4
`define TEW_SHAPE_POS_PER  3'h5
`define TEW_SHAPE_PATTERN  3'h6
// Reset values
`define TEW_RST_CTRL       32'h00000000
`define TEW_RST_WIDTH      32'h00000000
`define TEW_RST_PATTERN    32'h00000000
`define TEW_RST_CASCADE    32'h00000000
`endif

// ===== rtl/tew_sync.v
`timescale 1ns/1ps
`default_nettype none
module tew_sync #(
  parameter WIDTH = 1
) (
  input  wire             clock_i,
  input  wire             reset_n_i,
  input  wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  always @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule
`default_nettype wire

// ===== rtl/tew_launch.v
`timescale 1ns/1ps
`default_nettype none
module tew_launch (
  input  wire clock_i,
  input  wire reset_n_i,
  input  wire level_i,
  input  wire neg_edge_i,
  output wire wave_o
);
  reg rise_q;
  reg fall_q;

  always @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rise_q <= 1'b0;
    else
      rise_q <= level_i;
  end

  // Half-cycle retime of the rising-edge copy
  always @(negedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      fall_q <= 1'b0;
    else
      fall_q <= rise_q;
  end

  assign wave_o = neg_edge_i ? fall_q : rise_q;
endmodule
`default_nettype wire

// ===== dv/tew_peer.sv
`timescale 1ns/1ps
`default_nettype none
module tew_peer (
  input  wire logic       clock_i,
  input  wire logic [1:0] lvl_i,
  output logic            pin1_o,
  output logic            pin2_o
);
  // Other units on the shared pins, launched from flops
  initial {pin2_o, pin1_o} = 2'b00;
  always @(posedge clock_i)
    {pin2_o, pin1_o} <= lvl_i;
endmodule
`default_nettype wire

// ===== dv/tew_unit_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module tew_unit_chk (
  input wire logic        clock_i,
  input wire logic        reset_n_i,
  input wire logic [3:0]  reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic        reg_write_i,
  input wire logic        reg_read_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic        peer_pin1_i,
  input wire logic        peer_pin2_i,
  input wire logic        event_pin1_o,
  input wire logic        event_pin2_o
);
  logic [2:0] shp_q;
  logic       sel_q;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  // Taken off the write port, so a masked field shows up as a mismatch
  always_ff @(posedge clock_i or negedge reset_n_i)
    if (!reset_n_i)
      {shp_q, sel_q} <= 4'h0;
    else if (reg_write_i && reg_addr_i == 4'h0)
      {shp_q, sel_q} <= {reg_wdata_i[22:20], reg_wdata_i[16]};
  rd_idle_a: assert property (!$past(reg_read_i) |-> reg_rdata_o == 32'h0)
    else $error("read data not zero outside read cycle");
  unmapped_rd_a: assert property (reg_read_i && reg_addr_i > 4'h4 |=> reg_rdata_o == 32'h0)
    else $error("unmapped read not zero");
  rsvd_zero_a: assert property (reg_read_i && reg_addr_i == 4'h0
    |=> reg_rdata_o[27:24] == 4'h0 && reg_rdata_o[19:17] == 3'h0)
    else $error("reserved control bits not zero");
  shape_rb_a: assert property (reg_read_i && reg_addr_i == 4'h0
    |=> reg_rdata_o[22:20] == shp_q) else $error("shape field readback wrong");
  sel_rb_a: assert property (reg_read_i && reg_addr_i == 4'h0
    |=> reg_rdata_o[16] == sel_q) else $error("pin select readback wrong");
  peer1_or_a: assert property ($past(peer_pin1_i, 2) |-> event_pin1_o)
    else $error("peer level lost on pin one");
  peer2_or_a: assert property ($past(peer_pin2_i, 2) |-> event_pin2_o)
    else $error("peer level lost on pin two");
  pin2_free_a: assert property (!sel_q && !$past(sel_q, 4)
    |-> event_pin2_o == $past(peer_pin2_i, 2)) else $error("pin two driven while unselected");
  pin1_free_a: assert property (sel_q && $past(sel_q, 4)
    |-> event_pin1_o == $past(peer_pin1_i, 2)) else $error("pin one driven while unselected");
endmodule
bind tew_unit tew_unit_chk u_chk (.clock_i, .reset_n_i, .reg_addr_i, .reg_wdata_i,
  .reg_write_i, .reg_read_i, .reg_rdata_o, .peer_pin1_i, .peer_pin2_i, .event_pin1_o,
  .event_pin2_o);
`default_nettype wire

// ===== dv/tew_unit_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "tew_consts.vh"
module tew_unit_bench;
  localparam int W = 10;
  logic        clock_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic [3:0]  reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic        reg_write_i = 1'b0;
  logic        reg_read_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic        target_reached_i = 1'b0;
  logic [1:0]  lvl = 2'b00;
  logic        peer_pin1_i;
  logic        peer_pin2_i;
  logic        event_pin1_o;
  logic        event_pin2_o;
  logic [15:0] pat = 16'hA5C3;
  int          lim;
  int          n_mismatch;
  int          checks;
  int          cyc;
  always #2 clock_i = ~clock_i;
  tew_unit u_dut (.clock_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_write_i,
    .reg_read_i, .reg_rdata_o, .target_reached_i, .peer_pin1_i, .peer_pin2_i,
    .event_pin1_o, .event_pin2_o);
  tew_peer u_peer (.clock_i, .lvl_i(lvl), .pin1_o(peer_pin1_i), .pin2_o(peer_pin2_i));
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    {reg_addr_i, reg_wdata_i, reg_write_i} <= {a, d, 1'b1};
    @(posedge clock_i);
    reg_write_i <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clock_i);
    {reg_addr_i, reg_read_i} <= {a, 1'b1};
    @(posedge clock_i);
    reg_read_i <= 1'b0;
    #1 chk("rdata", reg_rdata_o, e);
  endtask
  // Bit 1 says whether the sample is defined, bit 0 the level
  function logic [1:0] ex(input logic [2:0] s, input int k);
    int b;
    b = k / W;
    if (k < 0)
      return (s == 3'h6) ? 2'b00 : {1'b1, s == 3'h0 || s == 3'h2 || s == 3'h4};
    case (s)
      3'h0: return 2'b10;
      3'h1: return 2'b11;
      3'h2: return {1'b1, b > 0};
      3'h3: return {1'b1, b == 0};
      3'h4: return {1'b1, b >= lim || b[0]};
      3'h5: return {1'b1, b < lim && !b[0]};
      default: return b < lim ? {1'b1, pat[15 - b % 16]} : 2'b00;
    endcase
  endfunction
  task hold(input bit p);
    logic v;
    @(posedge clock_i);
    #3 v = p ? event_pin2_o : event_pin1_o;
    repeat (30)
    begin
      @(posedge clock_i);
      #3 chk("hold", p ? event_pin2_o : event_pin1_o, v);
    end
  endtask
  task fire(input logic [31:0] c, input logic [31:0] pw, input int n, input bit st);
    logic [1:0] x;
    wr(`TEW_ADDR_WIDTH, W);
    wr(`TEW_ADDR_PATTERN, pw);
    wr(`TEW_ADDR_CTRL, c);
    wr(`TEW_ADDR_CTRL, c | 32'h80000000);
    @(posedge clock_i);
    target_reached_i <= 1'b1;
    for (int t = 0; t < n; t++)
    begin
      @(posedge clock_i);
      // Sampled early so the falling-edge copy shows one cycle later
      #1 x = ex(c[22:20], t - (c[23] ? 4 : 3));
      if (x[1]) chk("wave", c[16] ? event_pin2_o : event_pin1_o, x[0]);
    end
    if (st) hold(c[16]);
  endtask
  // Drop the trigger before touching control, so nothing re-arms
  task disarm(input logic [31:0] c);
    @(posedge clock_i);
    target_reached_i <= 1'b0;
    wr(`TEW_ADDR_CTRL, c);
    repeat (4) @(posedge clock_i);
  endtask
  task t_regs;
    rd(`TEW_ADDR_CTRL, `TEW_RST_CTRL);
    rd(`TEW_ADDR_WIDTH, `TEW_RST_WIDTH);
    rd(`TEW_ADDR_PATTERN, `TEW_RST_PATTERN);
    rd(`TEW_ADDR_CASCADE, `TEW_RST_CASCADE);
    rd(4'h9, 32'h0);
    wr(`TEW_ADDR_CTRL, 32'h0F7F0005);
    rd(`TEW_ADDR_CTRL, 32'h00710005);
    wr(`TEW_ADDR_CTRL, 32'h0);
  endtask
  task t_shapes;
    lim = 4;
    for (int s = 0; s < 6; s++)
    begin
      fire({8'h0, s == 2, s[2:0], 3'h0, s == 3, 16'h0}, 32'h00020000, 60, 1);
      disarm(32'h0);
    end
  endtask
  task t_patterns;
    lim = 12;
    fire(32'h00600000, {16'd12, pat}, 130, 1);
    disarm(32'h0);
    lim = 32;
    fire(32'h30600001, {16'h0, pat}, 330, 1);
    disarm(32'h0);
    lim = 40;
    fire(32'h20600000, {16'h0, pat}, 405, 0);
    disarm(32'hE0600000);
    hold(0);
    disarm(32'h0);
  endtask
  task t_peer;
    lim = 0;
    fire(32'h0, 32'h0, 8, 0);
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clock_i);
      lvl <= {2{i == 0}};
      repeat (4) @(posedge clock_i);
      #3 chk("pin1", event_pin1_o, i == 0);
      chk("pin2", event_pin2_o, i == 0);
    end
    disarm(32'h0);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge clock_i);
    reset_n_i <= 1'b1;
    t_regs;
    t_shapes;
    t_patterns;
    t_peer;
    wrap_up;
  end
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      wrap_up;
    end
  end
endmodule
`default_nettype wire
